// ### hw/rrss_core.sv
// Executor for return, rotate-through-carry, subtract and sleep instructions
// Overview of operation
// - Return from interrupt pops stack into program counter over two cycles.
// - Return from interrupt sets global interrupt enable bit 7; status unchanged.
// - Return from subroutine pops stack into program counter in two cycles.
// - Return with literal loads accumulator with literal, pops program counter.
// - Rotate left through carry: carry into bit 0, bit 7 out.
// - Rotate right through carry: carry into bit 7, bit 0 out.
// - Rotates and file subtract: destination bit 0 writes accumulator, 1 writes back file register.
// - Literal minus accumulator into accumulator, updating carry, nibble carry, zero.
// - File minus accumulator; carry and nibble carry mean no borrow.
// - Subtract with borrow also subtracts inverted carry.
// - Sleep clears watchdog and prescaler, sets timeout, clears powerdown, halts.
`timescale 1ns/100ps
`default_nettype none
module rrss_core
  import rrss_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Instruction issue
  input wire logic instr_valid,
  input wire rrss_instr_t instr,
  input wire logic sleep_req,
  output logic instr_ready,
  // Stack push from the call path
  input wire logic stack_push,
  input wire logic [RRSS_PC_W-1:0] push_addr,
  // Wake from sleep
  input wire logic wake,
  // Watchdog tick from the core's slow divider
  input wire logic wdt_tick,
  // Architectural state
  output logic [RRSS_PC_W-1:0] pc_q,
  output logic [7:0] acc_q,
  output rrss_flags_t status_q,
  output logic [7:0] interrupt_control_reg_q,
  output logic timeout_flag_q,
  output logic powerdown_flag_q,
  output logic [7:0] watchdog_counter_q,
  output logic [7:0] wdt_prescaler_q,
  output logic sleeping_q,
  output logic osc_run,
  // File register observation
  input wire logic [6:0] peek_addr,
  output logic [7:0] peek_data
);

  typedef enum logic [1:0] {
    RRSS_ST_RUN,
    RRSS_ST_RET,
    RRSS_ST_SLEEP
  } rrss_state_t;

  rrss_state_t state_q;
  logic [7:0] file_mem [RRSS_FILE_DEPTH];
  logic [RRSS_PC_W-1:0] stack_mem [RRSS_STACK_DEPTH];
  logic [3:0] sp_q;
  logic [3:0] sp_top;
  logic [RRSS_PC_W-1:0] stack_top;
  logic [7:0] file_rd;
  logic [7:0] sub_a;
  logic [7:0] sub_b;
  logic sub_cin;
  logic [7:0] sub_diff;
  rrss_flags_t sub_flags;
  logic [7:0] rot_res;
  logic rot_carry;
  logic [7:0] result_d;
  logic go;
  logic is_ret;
  logic is_rot;
  logic is_sub;
  logic write_file;
  logic write_acc;
  logic [7:0] peek_q;

  assign file_rd = file_mem[instr.file_addr];
  assign sp_top = sp_q - 4'h1;
  assign stack_top = stack_mem[sp_top];
  assign instr_ready = (state_q == RRSS_ST_RUN);
  assign go = instr_valid && instr_ready && !sleep_req;
  assign osc_run = !sleeping_q;
  assign is_ret = go && (instr.op inside {RRSS_OP_RET_IRQ, RRSS_OP_RET_SUB, RRSS_OP_RET_LIT});
  assign is_rot = go && (instr.op inside {RRSS_OP_ROT_LEFT, RRSS_OP_ROT_RIGHT});
  assign is_sub = go && (instr.op inside {RRSS_OP_LIT_SUB, RRSS_OP_FILE_SUB});

  // Operand selection for the shared subtractor
  always_comb
  begin
    sub_a = file_rd;
    sub_b = acc_q;
    sub_cin = 1'b1;
    if (instr.op == RRSS_OP_LIT_SUB)
    begin
      sub_a = instr.literal;
    end
    else if (instr.borrow_in)
    begin
      sub_cin = status_q.carry;
    end
  end

  rrss_sub u_sub (
    .minuend(sub_a),
    .subtrahend(sub_b),
    .carry_in(sub_cin),
    .diff(sub_diff),
    .flags(sub_flags)
  );

  // Rotates through carry
  always_comb
  begin
    if (instr.op == RRSS_OP_ROT_LEFT)
    begin
      rot_res = {file_rd[6:0], status_q.carry};
      rot_carry = file_rd[7];
    end
    else
    begin
      rot_res = {status_q.carry, file_rd[7:1]};
      rot_carry = file_rd[0];
    end
  end

  // Destination routing; literal subtract always lands in the accumulator
  always_comb
  begin
    result_d = is_rot ? rot_res : sub_diff;
    write_file = (is_rot || (is_sub && instr.op == RRSS_OP_FILE_SUB)) && instr.dest_file;
    write_acc = (is_rot || is_sub) && !write_file;
  end

  // Sequencing: returns take a second cycle, sleep parks until wake
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= RRSS_ST_RUN;
    end
    else
    begin
      unique case (state_q)
        RRSS_ST_RUN:
        begin
          if (instr_valid && sleep_req)
          begin
            state_q <= RRSS_ST_SLEEP;
          end
          else if (is_ret)
          begin
            state_q <= RRSS_ST_RET;
          end
        end
        RRSS_ST_RET:
        begin
          state_q <= RRSS_ST_RUN;
        end
        RRSS_ST_SLEEP:
        begin
          if (wake)
          begin
            state_q <= RRSS_ST_RUN;
          end
        end
      endcase
    end
  end

  assign sleeping_q = (state_q == RRSS_ST_SLEEP);

  // Program counter: the pop lands in the first cycle, second is the flush
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_q <= RRSS_PC_RST;
    end
    else if (is_ret)
    begin
      pc_q <= stack_top;
    end
    else if (go)
    begin
      pc_q <= pc_q + 15'h0001;
    end
  end

  // Stack pointer; wraps silently, overflow reporting lives elsewhere
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sp_q <= 4'h0;
    end
    else if (is_ret)
    begin
      sp_q <= sp_top;
    end
    else if (stack_push && instr_ready)
    begin
      sp_q <= sp_q + 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (stack_push && instr_ready && !is_ret)
    begin
      stack_mem[sp_q] <= push_addr;
    end
  end

  // Accumulator
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_q <= RRSS_ACC_RST;
    end
    else if (is_ret && instr.op == RRSS_OP_RET_LIT)
    begin
      acc_q <= instr.literal;
    end
    else if (write_acc)
    begin
      acc_q <= result_d;
    end
  end

  // File register array
  always_ff @(posedge clk)
  begin
    if (write_file)
    begin
      file_mem[instr.file_addr] <= result_d;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      peek_q <= RRSS_FILE_RST;
    end
    else
    begin
      peek_q <= file_mem[peek_addr];
    end
  end

  assign peek_data = peek_q;

  // Status flags; returns leave them alone
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      status_q <= '0;
    end
    else if (is_sub)
    begin
      status_q <= sub_flags;
    end
    else if (is_rot)
    begin
      status_q.carry <= rot_carry;
    end
  end

  // Interrupt control: only the enable bit is touched here
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      interrupt_control_reg_q <= RRSS_INTERRUPT_CONTROL_REG_RST;
    end
    else if (is_ret && instr.op == RRSS_OP_RET_IRQ)
    begin
      interrupt_control_reg_q[RRSS_GIE_BIT] <= 1'b1;
    end
  end

  // Watchdog; frozen while asleep since the oscillator is stopped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      watchdog_counter_q <= RRSS_WDT_CLEAR;
      wdt_prescaler_q <= RRSS_WDT_PRE_CLEAR;
    end
    else if (instr_ready && instr_valid && sleep_req)
    begin
      watchdog_counter_q <= RRSS_WDT_CLEAR;
      wdt_prescaler_q <= RRSS_WDT_PRE_CLEAR;
    end
    else if (wdt_tick && !sleeping_q)
    begin
      wdt_prescaler_q <= wdt_prescaler_q + 8'h01;
      if (wdt_prescaler_q == 8'hff)
      begin
        watchdog_counter_q <= watchdog_counter_q + 8'h01;
      end
    end
  end

  // Power status bits, both set at reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b1;
    end
    else if (instr_ready && instr_valid && sleep_req)
    begin
      timeout_flag_q <= 1'b1;
      powerdown_flag_q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ### hw/rrss_pkg.sv
// Shared types and constants for the return, rotate, subtract and sleep executor
package rrss_pkg;

  typedef enum logic [2:0] {
    RRSS_OP_NONE,
    RRSS_OP_RET_IRQ,
    RRSS_OP_RET_SUB,
    RRSS_OP_RET_LIT,
    RRSS_OP_ROT_LEFT,
    RRSS_OP_ROT_RIGHT,
    RRSS_OP_LIT_SUB,
    RRSS_OP_FILE_SUB
  } rrss_op_t;

  typedef struct packed {
    rrss_op_t op;
    logic borrow_in;
    logic dest_file;
    logic [6:0] file_addr;
    logic [7:0] literal;
  } rrss_instr_t;

  typedef struct packed {
    logic carry;
    logic nibble_carry;
    logic zero;
  } rrss_flags_t;

  localparam int RRSS_FILE_DEPTH = 128;
  localparam int RRSS_STACK_DEPTH = 16;
  localparam int RRSS_PC_W = 15;
  localparam int RRSS_GIE_BIT = 7;
  localparam logic [7:0] RRSS_ACC_RST = 8'h00;
  localparam logic [7:0] RRSS_FILE_RST = 8'h00;
  localparam logic [7:0] RRSS_INTERRUPT_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] RRSS_WDT_CLEAR = 8'h00;
  localparam logic [7:0] RRSS_WDT_PRE_CLEAR = 8'h00;
  localparam logic [RRSS_PC_W-1:0] RRSS_PC_RST = 15'h0000;
  localparam logic [1:0] RRSS_RET_CYCLES = 2'h2;

endpackage

// ### hw/rrss_sub.sv
// Eight-bit subtractor with carry, nibble carry and zero
`timescale 1ns/100ps
`default_nettype none
module rrss_sub
  import rrss_pkg::*;
(
  // Operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  input wire logic carry_in,
  // Result
  output logic [7:0] diff,
  output rrss_flags_t flags
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Two's complement: a + ~b + carry, carry set means no borrow
  assign full_sum = {1'b0, minuend} + {1'b0, ~subtrahend} + {8'h00, carry_in};
  assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~subtrahend[3:0]} + {4'h0, carry_in};
  assign diff = full_sum[7:0];
  assign flags.carry = full_sum[8];
  assign flags.nibble_carry = low_sum[4];
  assign flags.zero = (full_sum[7:0] == 8'h00);

endmodule
`default_nettype wire

// ### testbench/rrss_asserts.sv
// Port assertions for the executor
`timescale 1ns/100ps
`default_nettype none
module rrss_chk
  import rrss_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Issue
  input wire logic instr_valid,
  input wire rrss_instr_t instr,
  input wire logic sleep_req,
  input wire logic instr_ready,
  // State
  input wire logic [7:0] acc_q,
  input wire rrss_flags_t status_q,
  input wire logic [7:0] interrupt_control_reg_q,
  input wire logic timeout_flag_q,
  input wire logic powerdown_flag_q,
  input wire logic [7:0] watchdog_counter_q,
  input wire logic [7:0] wdt_prescaler_q,
  input wire logic sleeping_q,
  input wire logic osc_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic tk;
  rrss_op_t op;
  assign tk = instr_valid && instr_ready && !sleep_req;
  assign op = instr.op;
  ret_two_a: assert property (
    tk && op inside {RRSS_OP_RET_IRQ, RRSS_OP_RET_SUB, RRSS_OP_RET_LIT}
    |=> !instr_ready ##1 instr_ready) else $error("return length");
  ret_gie_a: assert property (
    tk && op == RRSS_OP_RET_IRQ |=> interrupt_control_reg_q[RRSS_GIE_BIT] && $stable(status_q))
    else $error("irq enable");
  ret_lit_a: assert property (
    tk && op == RRSS_OP_RET_LIT |=> acc_q == $past(instr.literal)) else $error("literal");
  rot_keep_a: assert property (
    tk && op inside {RRSS_OP_ROT_LEFT, RRSS_OP_ROT_RIGHT}
    |=> $stable(status_q.nibble_carry) && $stable(status_q.zero)) else $error("rotate flags");
  dest_file_a: assert property (
    tk && instr.dest_file && op inside {RRSS_OP_ROT_LEFT, RRSS_OP_ROT_RIGHT, RRSS_OP_FILE_SUB}
    |=> $stable(acc_q)) else $error("destination");
  lit_sub_a: assert property (
    tk && op == RRSS_OP_LIT_SUB |=> acc_q == $past(instr.literal) - $past(acc_q)
    && status_q.carry == ($past(acc_q) <= $past(instr.literal))) else $error("subtract");
  lit_zero_a: assert property (
    tk && op == RRSS_OP_LIT_SUB |=> status_q.zero == (acc_q == 8'h00)) else $error("zero");
  sleep_entry_a: assert property (
    instr_valid && instr_ready && sleep_req |=> sleeping_q && !osc_run && !instr_ready
    && timeout_flag_q && !powerdown_flag_q && {watchdog_counter_q, wdt_prescaler_q} == 16'h0000)
    else $error("sleep entry");
  cover property (tk && op == RRSS_OP_RET_LIT);
  cover property (tk && op == RRSS_OP_LIT_SUB ##1 status_q.zero);
  cover property (sleeping_q ##1 !sleeping_q);
  cover property (tk && op == RRSS_OP_FILE_SUB && instr.borrow_in);
endmodule
bind rrss_core rrss_chk rrss_chk_inst (.clk, .rstn, .instr_valid, .instr, .sleep_req,
  .instr_ready, .acc_q, .status_q, .interrupt_control_reg_q, .timeout_flag_q,
  .powerdown_flag_q, .watchdog_counter_q, .wdt_prescaler_q, .sleeping_q, .osc_run);
`default_nettype wire

// ### testbench/testbench.sv
// Directed bench for the executor
`timescale 1ns/100ps
`default_nettype none
module testbench
  import rrss_pkg::*;
;
  logic clk = 0, rstn = 0, instr_valid = 0, sleep_req = 0, stack_push = 0, wake = 0;
  logic wdt_tick = 0;
  rrss_instr_t instr = '0;
  logic [RRSS_PC_W-1:0] push_addr = '0, pc_q, e_pc;
  logic [6:0] peek_addr = 7'h05;
  logic instr_ready, timeout_flag_q, powerdown_flag_q, sleeping_q, osc_run;
  logic [7:0] acc_q, interrupt_control_reg_q, watchdog_counter_q, wdt_prescaler_q, peek_data;
  logic [7:0] e_acc, e_file;
  logic [7:0] ks [5] = '{8'h3c, 8'h05, 8'h13, 8'h0a, 8'hff};
  rrss_flags_t status_q, e_st;
  int err_count = 0, n_compared = 0;
  always #5 clk = ~clk;
  rrss_core rrss_core_inst (.clk, .rstn, .instr_valid, .instr, .sleep_req, .instr_ready,
    .stack_push, .push_addr, .wake, .wdt_tick, .pc_q, .acc_q, .status_q,
    .interrupt_control_reg_q, .timeout_flag_q, .powerdown_flag_q, .watchdog_counter_q,
    .wdt_prescaler_q, .sleeping_q, .osc_run, .peek_addr, .peek_data);
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  // Entered at a falling edge, leaves at the next; inputs stay up
  task automatic drv(input logic v, p, sl, input rrss_op_t op, input logic d, b,
    input logic [7:0] k);
    instr_valid = v;
    stack_push = p;
    sleep_req = sl;
    instr = '{op, b, d, 7'h05, k};
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic st();
    chk("acc", e_acc, acc_q);
    chk("status", e_st, status_q);
    chk("pc", e_pc, pc_q);
  endtask
  // Peek is registered, so one idle edge lets the last write show
  task automatic fchk();
    drv(1'b0, 1'b0, 1'b0, RRSS_OP_NONE, 1'b0, 1'b0, 8'h00);
    chk("file", e_file, peek_data);
  endtask
  task automatic push(input logic [14:0] a);
    push_addr = a;
    drv(1'b0, 1'b1, 1'b0, RRSS_OP_NONE, 1'b0, 1'b0, 8'h00);
  endtask
  task automatic ret(input rrss_op_t op, input logic [7:0] k, input logic [14:0] a);
    drv(1'b1, 1'b0, 1'b0, op, 1'b0, 1'b0, k);
    e_pc = a;
    if (op == RRSS_OP_RET_LIT)
      e_acc = k;
    st();
    chk("ready", 0, instr_ready);
    drv(1'b0, 1'b0, 1'b0, RRSS_OP_NONE, 1'b0, 1'b0, 8'h00);
    chk("ready", 1, instr_ready);
  endtask
  task automatic lsub(input logic [7:0] k);
    drv(1'b1, 1'b0, 1'b0, RRSS_OP_LIT_SUB, 1'b0, 1'b0, k);
    e_st = '{e_acc <= k, e_acc[3:0] <= k[3:0], e_acc == k};
    e_acc = k - e_acc;
    e_pc++;
    st();
  endtask
  // Reference model of the file word at address 05, the accumulator and the flags
  task automatic fop(input rrss_op_t op, input logic d, b);
    int t;
    int n;
    logic [7:0] r;
    if (op == RRSS_OP_ROT_LEFT)
    begin
      r = {e_file[6:0], e_st.carry};
      e_st.carry = e_file[7];
    end
    else if (op == RRSS_OP_ROT_RIGHT)
    begin
      r = {e_st.carry, e_file[7:1]};
      e_st.carry = e_file[0];
    end
    else
    begin
      t = int'(e_file) - int'(e_acc) - int'(b && !e_st.carry);
      n = int'(e_file[3:0]) - int'(e_acc[3:0]) - int'(b && !e_st.carry);
      r = t[7:0];
      e_st = '{t >= 0, n >= 0, r == 8'h00};
    end
    if (d)
      e_file = r;
    else
      e_acc = r;
    e_pc++;
    drv(1'b1, 1'b0, 1'b0, op, d, b, 8'h00);
    st();
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    err_count++;
    give_verdict();
  end
  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1;
    e_acc = 8'h00;
    e_pc = '0;
    e_st = '0;
    st();
    chk("to_pd", 16'h0003, {timeout_flag_q, powerdown_flag_q});
    push(15'h1234);
    push(15'h7fff);
    push(15'h0040);
    ret(RRSS_OP_RET_LIT, 8'hff, 15'h0040);
    ret(RRSS_OP_RET_SUB, 8'h00, 15'h7fff);
    chk("gie", 0, interrupt_control_reg_q[7]);
    ret(RRSS_OP_RET_IRQ, 8'h00, 15'h1234);
    chk("gie", 1, interrupt_control_reg_q[7]);
    // Second return cycle must ignore a held request
    push(15'h0100);
    drv(1'b1, 1'b0, 1'b0, RRSS_OP_RET_LIT, 1'b0, 1'b0, 8'h3c);
    drv(1'b1, 1'b0, 1'b0, RRSS_OP_RET_LIT, 1'b0, 1'b0, 8'h99);
    e_acc = 8'h3c;
    e_pc = 15'h0100;
    st();
    foreach (ks[i]) lsub(ks[i]);
    // File word starts unknown: each rotate shifts in a carry made known by a subtract
    repeat (8)
    begin
      lsub(8'hff);
      drv(1'b1, 1'b0, 1'b0, RRSS_OP_ROT_RIGHT, 1'b1, 1'b0, 8'h00);
      e_pc++;
    end
    e_file = 8'hff;
    lsub(8'h01);
    fop(RRSS_OP_ROT_LEFT, 1'b1, 1'b0);
    fop(RRSS_OP_ROT_RIGHT, 1'b0, 1'b0);
    lsub(8'hff);
    fchk();
    push(15'h0200);
    ret(RRSS_OP_RET_LIT, 8'h80, 15'h0200);
    lsub(8'h81);
    fop(RRSS_OP_ROT_RIGHT, 1'b0, 1'b0);
    push(15'h0300);
    ret(RRSS_OP_RET_LIT, 8'h11, 15'h0300);
    fop(RRSS_OP_FILE_SUB, 1'b1, 1'b0);
    fop(RRSS_OP_FILE_SUB, 1'b1, 1'b1);
    lsub(8'h00);
    fop(RRSS_OP_FILE_SUB, 1'b0, 1'b1);
    fop(RRSS_OP_FILE_SUB, 1'b1, 1'b0);
    fchk();
    drv(1'b0, 1'b0, 1'b0, RRSS_OP_NONE, 1'b0, 1'b0, 8'h00);
    wdt_tick = 1;
    repeat (300) @(negedge clk);
    wdt_tick = 0;
    chk("wdog", 16'h012c, {watchdog_counter_q, wdt_prescaler_q});
    drv(1'b1, 1'b0, 1'b1, RRSS_OP_NONE, 1'b0, 1'b0, 8'h00);
    chk("wdog", 16'h0000, {watchdog_counter_q, wdt_prescaler_q});
    chk("to_pd", 16'h0002, {timeout_flag_q, powerdown_flag_q});
    chk("halt", 16'h0004, {sleeping_q, osc_run, instr_ready});
    drv(1'b1, 1'b0, 1'b0, RRSS_OP_LIT_SUB, 1'b0, 1'b0, 8'h77);
    chk("acc", e_acc, acc_q);
    wake = 1;
    drv(1'b0, 1'b0, 1'b0, RRSS_OP_NONE, 1'b0, 1'b0, 8'h00);
    wake = 0;
    chk("halt", 16'h0003, {sleeping_q, osc_run, instr_ready});
    give_verdict();
  end
endmodule
`default_nettype wire
